//--- design/lpwk_pkg.sv
// Shared constants, register map and mode type of the wake-up controller.
// Assumes a single 40 MHz system clock and an AXI4-Lite register bus.
package lpwk_pkg;

	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam int          PORTA_W       = 8;
	localparam int          IRQ_W         = 4;
	localparam int          WDT_CNT_W     = 15;

	////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0]  OFS_MODE_CTRL  = 8'h00;
	localparam logic [7:0]  OFS_WDT_CTRL   = 8'h04;
	localparam logic [7:0]  OFS_PORTA_WAKE = 8'h08;
	localparam logic [7:0]  OFS_STATUS     = 8'h0c;

	// system_mode_control fields
	localparam int          MC_IDLE_SEL    = 0;
	localparam int          MC_FAST_WAKE   = 1;
	localparam int          MC_XTAL        = 2;
	localparam int          MC_WDT_SRC_SYS = 3;
	localparam int          MC_WDT_CFG_EN  = 4;
	localparam int          MC_LVD_ON      = 5;
	localparam int          MC_W           = 6;

	// watchdog_control fields
	localparam int          WC_SYSCLK_KEEP = 7;
	localparam int          WC_PERIOD_LSB  = 4;
	localparam int          WC_EN_LSB      = 0;

	// Status fields
	localparam int          ST_PDF         = 0;
	localparam int          ST_TO          = 1;
	localparam int          ST_ON_LOW_INTERNAL_RC     = 2;
	localparam int          ST_HALTED      = 3;

	// Reset values
	localparam logic [5:0]  RST_MODE_CTRL  = 6'h00;
	localparam logic [7:0]  RST_WDT_CTRL   = 8'h7a;
	localparam logic [7:0]  RST_PORTA_WAKE = 8'h00;
	localparam logic [3:0]  WDT_DIS_CODE   = 4'ha;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam logic [1:0]  SYS_DIV_LAST   = 2'h3;
	localparam logic [10:0] XTAL_WARM_CYC  = 11'h400;

	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_DECERR    = 2'h3;

	typedef enum logic [2:0] {
		LPWK_RUN,
		LPWK_IDLE0,
		LPWK_IDLE1,
		LPWK_SLEEP0,
		LPWK_SLEEP1
	} lpwk_mode_e;

	// Last count before overflow: 256 << sel, minus one
	function automatic logic [WDT_CNT_W-1:0] lpwk_wdt_last(input logic [2:0] sel);
		logic [15:0] t;
		t = 16'h0100 << sel;
		return t[WDT_CNT_W-1:0] - 15'h0001;
	endfunction

endpackage

//--- design/lpwk_wdt_if.sv
// Link between the controller and its watchdog counter.
// Assumes both ends share i_clk_sys.
`timescale 1ns/1ps
interface lpwk_wdt_if;
	logic       tick;
	logic       clear;
	logic       enable;
	logic [2:0] period_sel;
	logic       overflow;

	modport ctl (output tick, output clear, output enable, output period_sel,
		input overflow);
	modport wdt (input tick, input clear, input enable, input period_sel,
		output overflow);
endinterface

//--- design/lpwk_sync_edge.sv
// Two-flop synchroniser with edge pulses for a group of pins.
// Assumes the inputs are asynchronous to i_clk_sys.
`timescale 1ns/1ps
module lpwk_sync_edge #(
	parameter int           W       = 8,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_nrst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_level,
	output logic      [W-1:0] o_fall,
	output logic      [W-1:0] o_rise
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] last_q;

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
			last_q <= RST_VAL;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// Edges come from the second and third flops only
	assign o_level = sync_q;
	assign o_fall  = last_q & ~sync_q;
	assign o_rise  = ~last_q & sync_q;
endmodule

//--- design/lpwk_wdt.sv
// Watchdog counter with power-of-two time-out.
// Assumes ticks arrive as one-cycle enables from the controller.
`timescale 1ns/1ps
module lpwk_wdt (
	input  wire logic i_clk_sys,
	input  wire logic i_nrst,
	lpwk_wdt_if.wdt   wdt
);
	import lpwk_pkg::*;

	logic [WDT_CNT_W-1:0] cnt_q;
	logic                 ovf_q;
	logic                 at_last;

	assign at_last = (cnt_q >= lpwk_wdt_last(wdt.period_sel));

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_q <= '0;
			ovf_q <= 1'b0;
		end else begin
			ovf_q <= 1'b0;
			if (wdt.clear || !wdt.enable) begin
				cnt_q <= '0;
			end else if (wdt.tick) begin
				if (at_last) begin
					cnt_q <= '0;
					ovf_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 15'h0001;
				end
			end
		end
	end

	assign wdt.overflow = ovf_q;

	a_wdt_clear_zero: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		wdt.clear |=> (cnt_q == '0))
		else $error("watchdog not cleared");

	a_wdt_ovf_count: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(wdt.tick && wdt.enable && !wdt.clear && cnt_q == lpwk_wdt_last(wdt.period_sel))
		|=> (ovf_q && cnt_q == '0))
		else $error("watchdog overflow at wrong count");
endmodule

//--- design/lpwk_ctrl.sv
// Power-mode and wake-up controller: modes, flags, wake sources, watchdog
// clocking, fast-wake clock fallback and the AXI4-Lite register slave.
// Assumes the core pulses i_halt_exec and i_clrwdt_exec on i_clk_sys and
// keeps its own interrupt flags, enables and stack state.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// How it works
// - Halt with idle_select=1 and idle_sysclk_keep=1 enters clock-running idle.
// - In that idle, system, time base and sub clocks run; core halts.
// - Entering low power leaves memory, registers and ports untouched.
// - Entering clock-running idle clears the watchdog, which keeps counting.
// - Halt sets powerdown_flag and clears timeout_flag.
// - Wake on external reset, Port A fall, interrupt or watchdog overflow.
// - External reset wake gives full reset; watchdog wake resets only PC and stack pointer.
// - powerdown_flag cleared by power-up or watchdog clear, set by halt.
// - Overflow while down sets timeout_flag, resets only PC and stack pointer.
// - Masked Port A falling edges wake; execution resumes after halt.
// - Disabled or stack-full waking interrupt resumes after halt, stays pending.
// - Enabled interrupt with free stack level gets immediate interrupt response.
// - Interrupt already flagged at entry cannot wake the device.
// - Fast wake from clocked sleep on crystal runs system clock from internal RC first.
// - Peripherals on the system clock follow its switch to the slow source.
// - Watchdog clock is sub_clock or system clock divided by four.
// - Watchdog time-out is source clock prescaled by 2^8 to 2^15.
// - Three-bit period code selects 256 to 32768 periods, doubling.
// - Bit 7 of watchdog_control keeps system clock during idle.
// - Halt with idle_select=1 and keep=0 stops system clock only.
module lpwk_ctrl (
	input  wire logic                           i_clk_sys,
	input  wire logic                           i_nrst,
	// AXI4-Lite slave
	input  wire logic                           i_s_axi_awvalid,
	output logic                                o_s_axi_awready,
	input  wire logic [lpwk_pkg::ADDR_W-1:0]    i_s_axi_awaddr,
	input  wire logic                           i_s_axi_wvalid,
	output logic                                o_s_axi_wready,
	input  wire logic [lpwk_pkg::DATA_W-1:0]    i_s_axi_wdata,
	input  wire logic [3:0]                     i_s_axi_wstrb,
	output logic                                o_s_axi_bvalid,
	input  wire logic                           i_s_axi_bready,
	output logic [1:0]                          o_s_axi_bresp,
	input  wire logic                           i_s_axi_arvalid,
	output logic                                o_s_axi_arready,
	input  wire logic [lpwk_pkg::ADDR_W-1:0]    i_s_axi_araddr,
	output logic                                o_s_axi_rvalid,
	input  wire logic                           i_s_axi_rready,
	output logic [lpwk_pkg::DATA_W-1:0]         o_s_axi_rdata,
	output logic [1:0]                          o_s_axi_rresp,
	// Core side
	input  wire logic                           i_halt_exec,
	input  wire logic                           i_clrwdt_exec,
	input  wire logic [lpwk_pkg::IRQ_W-1:0]     i_irq_flag,
	input  wire logic [lpwk_pkg::IRQ_W-1:0]     i_irq_enable,
	input  wire logic                           i_stack_full,
	// Pins
	input  wire logic                           i_ext_rst_n,
	input  wire logic [lpwk_pkg::PORTA_W-1:0]   i_porta,
	input  wire logic                           i_low_internal_rc_clk,
	// Outputs
	output logic                                o_cpu_halt,
	output logic                                o_sysclk_en,
	output logic                                o_tbclk_en,
	output logic                                o_subclk_en,
	output logic                                o_sysclk_on_low_internal_rc,
	output logic                                o_sys_reset,
	output logic                                o_wdt_reset,
	output logic                                o_pcsp_reset,
	output logic                                o_resume,
	output logic                                o_int_response
);
	import lpwk_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// Registers and state
	logic [MC_W-1:0]    mode_ctrl_q;
	logic [7:0]         wdt_ctrl_q;
	logic [PORTA_W-1:0] porta_wake_mask_q;
	logic               pdf_q;
	logic               to_q;
	lpwk_mode_e         mode_q;
	logic [IRQ_W-1:0]   irq_armed_q;
	logic               on_low_internal_rc_q;
	logic [10:0]        warm_cnt_q;
	logic [1:0]         div4_q;
	logic               sys_reset_q;
	logic               wdt_reset_q;
	logic               pcsp_reset_q;
	logic               resume_q;
	logic               int_resp_q;

	logic [PORTA_W-1:0] pa_fall;
	logic [1:0]         misc_fall;
	logic [1:0]         misc_rise;
	logic               ext_rst_fall;
	logic               sub_tick;
	logic               wdt_en;
	logic               low_power;
	logic               sys_run;
	logic               sys_tick;
	logic               sys4_tick;
	logic               pa_wake;
	logic [IRQ_W-1:0]   irq_wake;
	logic               irq_serve;
	logic               halt_take;

	lpwk_wdt_if wdt_if ();

	lpwk_sync_edge #(.W(PORTA_W), .RST_VAL({PORTA_W{1'b1}})) u_porta_sync (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_async   (i_porta),
		.o_level   (),
		.o_fall    (pa_fall),
		.o_rise    ()
	);

	// Bit 1: external reset pin, bit 0: internal RC clock
	lpwk_sync_edge #(.W(2), .RST_VAL(2'h2)) u_misc_sync (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_async   ({i_ext_rst_n, i_low_internal_rc_clk}),
		.o_level   (),
		.o_fall    (misc_fall),
		.o_rise    (misc_rise)
	);

	lpwk_wdt u_wdt (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.wdt       (wdt_if.wdt)
	);

	assign ext_rst_fall = misc_fall[1];
	assign sub_tick     = misc_rise[0];

	//////////////////////////////////////////////////////////////////////////
	// Mode decode and clocks
	assign low_power = (mode_q != LPWK_RUN);
	assign sys_run   = (mode_q == LPWK_RUN) || (mode_q == LPWK_IDLE1);
	assign wdt_en    = mode_ctrl_q[MC_WDT_CFG_EN] ||
		(wdt_ctrl_q[WC_EN_LSB +: 4] != WDT_DIS_CODE);
	assign halt_take = i_halt_exec && (mode_q == LPWK_RUN);

	assign o_cpu_halt       = low_power;
	assign o_sysclk_en      = sys_run;
	assign o_tbclk_en       = (mode_q != LPWK_SLEEP0) && (mode_q != LPWK_SLEEP1);
	assign o_subclk_en      = (mode_q != LPWK_SLEEP0);
	assign o_sysclk_on_low_internal_rc = on_low_internal_rc_q;

	// While on the slow source every system-clock user slows with it
	assign sys_tick  = sys_run && (on_low_internal_rc_q ? sub_tick : 1'b1);
	assign sys4_tick = sys_tick && (div4_q == SYS_DIV_LAST);

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			div4_q <= 2'h0;
		end else if (sys_tick) begin
			div4_q <= div4_q + 2'h1;
		end
	end

	// Source is a fixed option, modelled as a control bit
	assign wdt_if.tick = mode_ctrl_q[MC_WDT_SRC_SYS] ? sys4_tick :
		(o_subclk_en && sub_tick);
	assign wdt_if.clear      = halt_take || i_clrwdt_exec || ext_rst_fall;
	assign wdt_if.enable     = wdt_en;
	assign wdt_if.period_sel = wdt_ctrl_q[WC_PERIOD_LSB +: 3];

	//////////////////////////////////////////////////////////////////////////
	// Wake sources
	assign pa_wake   = |(pa_fall & porta_wake_mask_q);
	assign irq_wake  = i_irq_flag & irq_armed_q;
	assign irq_serve = |(irq_wake & i_irq_enable) && !i_stack_full;

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_armed_q <= '0;
		end else if (halt_take) begin
			irq_armed_q <= ~i_irq_flag;
		end
	end

	// Priority while down: reset pin, watchdog, Port A, interrupt
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			mode_q       <= LPWK_RUN;
			sys_reset_q  <= 1'b0;
			wdt_reset_q  <= 1'b0;
			pcsp_reset_q <= 1'b0;
			resume_q     <= 1'b0;
			int_resp_q   <= 1'b0;
		end else begin
			sys_reset_q  <= 1'b0;
			wdt_reset_q  <= 1'b0;
			pcsp_reset_q <= 1'b0;
			resume_q     <= 1'b0;
			int_resp_q   <= 1'b0;
			if (ext_rst_fall) begin
				mode_q      <= LPWK_RUN;
				sys_reset_q <= 1'b1;
			end else if (wdt_if.overflow) begin
				mode_q       <= LPWK_RUN;
				wdt_reset_q  <= !low_power;
				pcsp_reset_q <= low_power;
			end else if (low_power && pa_wake) begin
				mode_q   <= LPWK_RUN;
				resume_q <= 1'b1;
			end else if (low_power && (|irq_wake)) begin
				mode_q     <= LPWK_RUN;
				int_resp_q <= irq_serve;
				resume_q   <= !irq_serve;
			end else if (halt_take) begin
				// Only the mode changes; data and port state are left alone
				if (mode_ctrl_q[MC_IDLE_SEL]) begin
					mode_q <= wdt_ctrl_q[WC_SYSCLK_KEEP] ? LPWK_IDLE1 :
						LPWK_IDLE0;
				end else begin
					mode_q <= (wdt_en || mode_ctrl_q[MC_LVD_ON]) ? LPWK_SLEEP1 :
						LPWK_SLEEP0;
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Fast wake fallback to the internal RC until the crystal warms up
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			on_low_internal_rc_q  <= 1'b0;
			warm_cnt_q <= 11'h000;
		end else if (mode_q == LPWK_SLEEP1 && !ext_rst_fall &&
			(wdt_if.overflow || pa_wake || (|irq_wake)) &&
			mode_ctrl_q[MC_XTAL] && mode_ctrl_q[MC_FAST_WAKE]) begin
			on_low_internal_rc_q  <= 1'b1;
			warm_cnt_q <= 11'h000;
		end else if (on_low_internal_rc_q) begin
			warm_cnt_q <= warm_cnt_q + 11'h001;
			if (warm_cnt_q == XTAL_WARM_CYC - 11'h001) begin
				on_low_internal_rc_q <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Status flags; a set in the same cycle as a clear wins
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			pdf_q <= 1'b0;
		end else if (halt_take) begin
			pdf_q <= 1'b1;
		end else if (i_clrwdt_exec) begin
			pdf_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			to_q <= 1'b0;
		end else if (wdt_if.overflow) begin
			to_q <= 1'b1;
		end else if (halt_take) begin
			to_q <= 1'b0;
		end
	end

	assign o_sys_reset    = sys_reset_q;
	assign o_wdt_reset    = wdt_reset_q;
	assign o_pcsp_reset   = pcsp_reset_q;
	assign o_resume       = resume_q;
	assign o_int_response = int_resp_q;

	//////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave, one write and one read at a time
	logic               aw_full_q;
	logic               w_full_q;
	logic [ADDR_W-1:0]  awaddr_q;
	logic [7:0]         wbyte_q;
	logic               wlane_q;
	logic               bvalid_q;
	logic [1:0]         bresp_q;
	logic               rvalid_q;
	logic [DATA_W-1:0]  rdata_q;
	logic [1:0]         rresp_q;
	logic               do_write;

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		return (a == OFS_MODE_CTRL) || (a == OFS_WDT_CTRL) ||
			(a == OFS_PORTA_WAKE) || (a == OFS_STATUS);
	endfunction

	assign o_s_axi_awready = !aw_full_q && !bvalid_q;
	assign o_s_axi_wready  = !w_full_q && !bvalid_q;
	assign o_s_axi_arready = !rvalid_q;
	assign do_write        = aw_full_q && w_full_q && !bvalid_q;

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awaddr_q  <= '0;
			wbyte_q   <= 8'h00;
			wlane_q   <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				aw_full_q <= 1'b1;
				awaddr_q  <= i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				w_full_q <= 1'b1;
				wbyte_q  <= i_s_axi_wdata[7:0];
				wlane_q  <= i_s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= addr_hit(awaddr_q) ? RESP_OKAY : RESP_DECERR;
			end else if (bvalid_q && i_s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			mode_ctrl_q       <= RST_MODE_CTRL;
			wdt_ctrl_q        <= RST_WDT_CTRL;
			porta_wake_mask_q <= RST_PORTA_WAKE;
		end else if (do_write && wlane_q) begin
			if (awaddr_q == OFS_MODE_CTRL) begin
				mode_ctrl_q <= wbyte_q[MC_W-1:0];
			end
			if (awaddr_q == OFS_WDT_CTRL) begin
				wdt_ctrl_q <= wbyte_q;
			end
			if (awaddr_q == OFS_PORTA_WAKE) begin
				porta_wake_mask_q <= wbyte_q;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end else if (i_s_axi_arvalid && o_s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q  <= addr_hit(i_s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
			unique case (i_s_axi_araddr)
				OFS_MODE_CTRL:  rdata_q <= {26'h0, mode_ctrl_q};
				OFS_WDT_CTRL:   rdata_q <= {24'h0, wdt_ctrl_q};
				OFS_PORTA_WAKE: rdata_q <= {24'h0, porta_wake_mask_q};
				OFS_STATUS:     rdata_q <= {28'h0, low_power, on_low_internal_rc_q, to_q, pdf_q};
				default:        rdata_q <= '0;
			endcase
		end else if (rvalid_q && i_s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign o_s_axi_bvalid = bvalid_q;
	assign o_s_axi_bresp  = bresp_q;
	assign o_s_axi_rvalid = rvalid_q;
	assign o_s_axi_rdata  = rdata_q;
	assign o_s_axi_rresp  = rresp_q;

	//////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	sequence s_quiet;
		!ext_rst_fall && !wdt_if.overflow;
	endsequence
	sequence s_enter_idle1;
		halt_take && mode_ctrl_q[MC_IDLE_SEL] && wdt_ctrl_q[WC_SYSCLK_KEEP] && !pa_wake;
	endsequence

	a_idle1_clocks_on: assert property (s_enter_idle1 ##0 s_quiet |=>
		(mode_q == LPWK_IDLE1) && o_sysclk_en && o_tbclk_en && o_subclk_en && o_cpu_halt)
		else $error("idle with clock not entered");
	a_idle0_sysclk_off: assert property ((mode_q == LPWK_IDLE0) |->
		!o_sysclk_en && o_tbclk_en && o_subclk_en)
		else $error("idle clock gating wrong");
	a_halt_flags_set: assert property (halt_take && !wdt_if.overflow |=> pdf_q && !to_q)
		else $error("halt flags wrong");
	a_clrwdt_pdf_clear: assert property (i_clrwdt_exec && !halt_take |=> !pdf_q)
		else $error("powerdown flag not cleared");
	a_ext_reset_wake: assert property (ext_rst_fall |=> o_sys_reset && !o_cpu_halt)
		else $error("external reset wake wrong");
	a_wdt_sleep_wake: assert property (wdt_if.overflow && low_power && !ext_rst_fall |=>
		to_q && o_pcsp_reset && !o_wdt_reset && !o_cpu_halt)
		else $error("watchdog wake wrong");
	a_porta_wake_resume: assert property (low_power && pa_wake ##0 s_quiet |=>
		o_resume && !o_cpu_halt ##1 !o_resume)
		else $error("port wake wrong");
	a_irq_serve_now: assert property (low_power && irq_serve && !pa_wake ##0 s_quiet |=>
		o_int_response && !o_resume)
		else $error("interrupt response missing");
	a_irq_defer_resume: assert property (low_power && (|irq_wake) && !irq_serve && !pa_wake
		##0 s_quiet |=> o_resume && !o_int_response)
		else $error("deferred interrupt wrong");
	a_irq_flagged_nowake: assert property (low_power && !(|irq_wake) && !pa_wake ##0 s_quiet
		|=> low_power)
		else $error("stale interrupt woke device");
	a_fast_wake_low_internal_rc: assert property ($rose(on_low_internal_rc_q) |-> $past(mode_q == LPWK_SLEEP1)
		&& !o_cpu_halt)
		else $error("fast wake fallback wrong");
endmodule

//--- verification/lpwk_pins_model.sv
// Pin-side model: internal RC oscillator and Port A pins with pull-ups.
// Assumes the bench pulls pins low through i_pull_low.
`timescale 1ns/1ps
module lpwk_pins_model (
	input  wire logic [7:0] i_pull_low,
	output logic            o_low_internal_rc_clk,
	output logic [7:0]      o_porta
);
	// Oscillator sped up so watchdog runs stay short
	initial begin
		o_low_internal_rc_clk = 1'b0;
		forever #150 o_low_internal_rc_clk = ~o_low_internal_rc_clk;
	end
	// Released pins rest at the pull-up level
	assign o_porta = ~i_pull_low;
endmodule

//--- verification/tb.sv
// Self-checking bench for the power-mode and wake-up controller.
// Assumes the package, watchdog link, design and pin model compile first.
`timescale 1ns/1ps
module tb;
	import lpwk_pkg::*;
	logic        i_clk_sys, i_nrst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
	logic        i_s_axi_arvalid, i_s_axi_rready, i_halt_exec, i_clrwdt_exec, i_stack_full;
	logic        i_ext_rst_n, i_low_internal_rc_clk, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
	logic        o_s_axi_arready, o_s_axi_rvalid, o_cpu_halt, o_sysclk_en, o_tbclk_en;
	logic        o_subclk_en, o_sysclk_on_low_internal_rc, o_sys_reset, o_wdt_reset, o_pcsp_reset;
	logic        o_resume, o_int_response;
	logic [7:0]  i_s_axi_awaddr, i_s_axi_araddr, i_porta, pull;
	logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rd_q;
	logic [3:0]  i_s_axi_wstrb, i_irq_flag, i_irq_enable;
	logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, rs_q, bs_q;
	logic [4:0]  seen;
	int          n_fail, comparisons, cyc;
	wire  [4:0]  ev = {o_sys_reset, o_wdt_reset, o_pcsp_reset, o_resume, o_int_response};
	lpwk_ctrl i_lpwk_ctrl (.i_clk_sys, .i_nrst, .i_s_axi_awvalid, .o_s_axi_awready,
		.i_s_axi_awaddr, .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata, .i_s_axi_wstrb,
		.o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid, .o_s_axi_arready,
		.i_s_axi_araddr, .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata, .o_s_axi_rresp,
		.i_halt_exec, .i_clrwdt_exec, .i_irq_flag, .i_irq_enable, .i_stack_full, .i_ext_rst_n,
		.i_porta, .i_low_internal_rc_clk, .o_cpu_halt, .o_sysclk_en, .o_tbclk_en, .o_subclk_en,
		.o_sysclk_on_low_internal_rc, .o_sys_reset, .o_wdt_reset, .o_pcsp_reset, .o_resume,
		.o_int_response);
	lpwk_pins_model i_lpwk_pins_model (.i_pull_low(pull), .o_low_internal_rc_clk(i_low_internal_rc_clk),
		.o_porta(i_porta));
	initial begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// Pulses last one cycle, so each edge is sampled and or-ed
	task automatic watch(input int k);
		seen = '0;
		repeat (k) begin
			@(posedge i_clk_sys);
			seen |= ev;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_awaddr <= a;
		i_s_axi_wvalid <= 1'b1;
		i_s_axi_wdata <= d;
		while (pa || pw) begin
			@(posedge i_clk_sys);
			if (pa && o_s_axi_awready) begin
				pa = 1'b0;
				i_s_axi_awvalid <= 1'b0;
			end
			if (pw && o_s_axi_wready) begin
				pw = 1'b0;
				i_s_axi_wvalid <= 1'b0;
			end
		end
		i_s_axi_bready <= 1'b1;
		do @(posedge i_clk_sys); while (o_s_axi_bvalid !== 1'b1);
		bs_q = o_s_axi_bresp;
		i_s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		i_s_axi_arvalid <= 1'b1;
		i_s_axi_araddr <= a;
		do @(posedge i_clk_sys); while (o_s_axi_arready !== 1'b1);
		i_s_axi_arvalid <= 1'b0;
		i_s_axi_rready <= 1'b1;
		do @(posedge i_clk_sys); while (o_s_axi_rvalid !== 1'b1);
		rd_q = o_s_axi_rdata;
		rs_q = o_s_axi_rresp;
		i_s_axi_rready <= 1'b0;
	endtask
	task automatic halt();
		i_halt_exec <= 1'b1;
		@(posedge i_clk_sys);
		i_halt_exec <= 1'b0;
		watch(2);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd(OFS_WDT_CTRL);
		chk("watchdog_control", rd_q, 32'h0000007a);
		rd(8'h10);
		chk("unmapped", {rd_q[29:0], rs_q}, {30'h0, RESP_DECERR});
		wr(8'h10, 32'h55);
		chk("wr unmapped", bs_q, RESP_DECERR);
		i_s_axi_wstrb <= 4'he;
		wr(OFS_PORTA_WAKE, 32'hff);
		i_s_axi_wstrb <= 4'hf;
		rd(OFS_PORTA_WAKE);
		chk("lane off", {rd_q[29:0], bs_q}, {30'h0, RESP_OKAY});
	endtask
	task automatic t_idle1();
		wr(OFS_MODE_CTRL, 32'h01);
		wr(OFS_WDT_CTRL, 32'h8a);
		wr(OFS_PORTA_WAKE, 32'h01);
		halt();
		chk("idle1", {o_cpu_halt, o_sysclk_en, o_tbclk_en, o_subclk_en}, 4'hf);
		rd(OFS_STATUS);
		chk("flags", rd_q[1:0], 2'h1);
		pull <= 8'h02;
		watch(10);
		chk("masked", seen, 5'h00);
		pull <= 8'h03;
		watch(10);
		chk("pa wake", {seen, o_cpu_halt}, 6'h04);
		pull <= 8'h00;
		i_clrwdt_exec <= 1'b1;
		watch(1);
		i_clrwdt_exec <= 1'b0;
		rd(OFS_STATUS);
		chk("pdf clr", rd_q[0], 1'b0);
	endtask
	task automatic irq_case(input logic full, input logic pre, input logic [4:0] e);
		i_stack_full <= full;
		i_irq_flag <= {3'h0, pre};
		halt();
		i_irq_flag <= 4'h1;
		watch(8);
		chk("irq wake", seen, e);
		i_irq_flag <= 4'h0;
		i_stack_full <= 1'b0;
		pull <= 8'h01;
		watch(8);
		pull <= 8'h00;
	endtask
	task automatic t_idle0();
		wr(OFS_WDT_CTRL, 32'h0a);
		i_irq_enable <= 4'h1;
		halt();
		chk("idle0", {o_cpu_halt, o_sysclk_en, o_tbclk_en, o_subclk_en}, 4'hb);
		pull <= 8'h01;
		watch(8);
		pull <= 8'h00;
		irq_case(1'b0, 1'b0, 5'h01);
		irq_case(1'b1, 1'b0, 5'h02);
		irq_case(1'b0, 1'b1, 5'h00);
	endtask
	task automatic t_wdt();
		wr(OFS_MODE_CTRL, 32'h09);
		wr(OFS_WDT_CTRL, 32'h85);
		i_clrwdt_exec <= 1'b1;
		watch(1);
		i_clrwdt_exec <= 1'b0;
		watch(1000);
		chk("early", seen, 5'h00);
		watch(60);
		chk("wdt run", seen, 5'h08);
		halt();
		watch(1000);
		chk("early dn", seen, 5'h00);
		watch(60);
		chk("wdt down", seen, 5'h04);
		rd(OFS_STATUS);
		chk("to pdf", rd_q[1:0], 2'h3);
		wr(OFS_WDT_CTRL, 32'h8a);
		halt();
		i_ext_rst_n <= 1'b0;
		watch(8);
		chk("ext rst", {seen, o_cpu_halt}, 6'h20);
		i_ext_rst_n <= 1'b1;
		watch(6);
	endtask
	// Watchdog stays disabled here; the voltage detector alone selects the clocked sleep
	task automatic t_sleep();
		wr(OFS_MODE_CTRL, 32'h06);
		halt();
		chk("sleep0", {o_cpu_halt, o_sysclk_en, o_tbclk_en, o_subclk_en}, 4'h8);
		pull <= 8'h01;
		watch(8);
		chk("no fast", {seen, o_sysclk_on_low_internal_rc}, 6'h04);
		pull <= 8'h00;
		wr(OFS_MODE_CTRL, 32'h26);
		halt();
		chk("sleep1", {o_cpu_halt, o_sysclk_en, o_tbclk_en, o_subclk_en}, 4'h9);
		pull <= 8'h01;
		watch(8);
		chk("fast wake", {seen, o_sysclk_on_low_internal_rc}, 6'h05);
		watch(1000);
		chk("on rc", o_sysclk_on_low_internal_rc, 1'b1);
		watch(30);
		chk("xtal back", o_sysclk_on_low_internal_rc, 1'b0);
		pull <= 8'h00;
	endtask
	initial begin
		{i_nrst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid} = '0;
		{i_s_axi_rready, i_halt_exec, i_clrwdt_exec, i_stack_full, pull} = '0;
		{i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, i_irq_flag, i_irq_enable} = '0;
		i_s_axi_wstrb = 4'hf;
		i_ext_rst_n = 1'b1;
		repeat (10) @(posedge i_clk_sys);
		i_nrst <= 1'b1;
		watch(4);
		t_regs();
		t_idle1();
		t_idle0();
		t_wdt();
		t_sleep();
		report_and_stop();
	end
endmodule
